// ===== utf_token_status.sv
// USB front-end token status, endpoint marking and PHY control registers
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`default_nettype none
module utf_token_status
	import utf_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_b,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Token decoder input
	input  wire logic              tok_valid,
	input  wire logic [3:0]        tok_pid,
	input  wire logic [6:0]        tok_addr,
	input  wire logic [3:0]        tok_ep,
	// Receive port endpoint output
	output logic                   rx_ep_valid,
	output logic      [4:0]        rx_ep,
	// Transceiver side
	input  wire logic [1:0]        line_state,
	input  wire logic              suspended,
	output logic      [1:0]        line_state_filt,
	output logic                   resume_req,
	output logic      [2:0]        transceiver_config_pins,
	output logic                   data_port_a_pulldown_en,
	output logic                   data_port_b_pulldown_en,
	// Interrupt
	output logic                   irq
);
	logic [6:0]           dev_addr_r;
	logic [3:0]           pid_r;
	logic [3:0]           ep_r;
	logic                 ep_valid_r;
	logic [15:0]          ep_special_r;
	logic [31:0]          otg_mask_r;
	logic [PWR_SIG_W-1:0] pwr_sig_r;
	logic [31:0]          phy_ctrl_r;
	logic [IRQ_W-1:0]     irq_status_r;
	logic [IRQ_W-1:0]     irq_mask_r;
	logic [31:0]          prdata_r;
	logic                 rx_ep_valid_r;
	logic [4:0]           rx_ep_r;
	logic                 resume_req_r;
	utf_susp_type         susp_r;
	logic                 wr_en;
	logic                 rd_en;
	logic                 mapped;
	logic                 tok_hit;
	logic                 res_se0;
	logic                 res_k;
	logic [31:0]          rd_mux;
	logic [IRQ_W-1:0]     irq_evt;

	utf_apb_regs u_dec (
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.wr_en   (wr_en),
		.rd_en   (rd_en),
		.mapped  (mapped)
	);

	utf_line_filter #(.CNT_W(17)) u_filt (
		.mclk       (mclk),
		.rst_b      (rst_b),
		.log2_delay (phy_ctrl_r[PHY_FILT_MSB:PHY_FILT_LSB]),
		.ls_raw     (line_state),
		.ls_filt    (line_state_filt)
	);

	// Zero-wait slave; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_r;

	assign tok_hit = tok_valid && (tok_addr == dev_addr_r);

	// Auto-resume events seen while suspended
	assign res_se0 = (susp_r == ST_SUSPEND) && (line_state_filt == LS_SE0);
	assign res_k   = (susp_r == ST_SUSPEND) && (line_state_filt == LS_K);

	// Device address, programmed after enumeration
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			dev_addr_r <= '0;
		else if (wr_en && paddr == OFF_DEV_ADDR)
			dev_addr_r <= pwdata[6:0];
	end

	// Last token capture; software cannot write these
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pid_r      <= '0;
			ep_r       <= '0;
			ep_valid_r <= 1'b0;
		end
		else if (tok_hit)
		begin
			pid_r      <= tok_pid;
			ep_r       <= tok_ep;
			ep_valid_r <= 1'b1;
		end
	end

	// Plain writable registers, masked to their fields
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ep_special_r <= '0;
			otg_mask_r   <= '0;
			pwr_sig_r    <= '0;
			irq_mask_r   <= '0;
		end
		else if (wr_en)
		begin
			if (paddr == OFF_EP_SPECIAL)
				ep_special_r <= pwdata[15:0];
			if (paddr == OFF_OTG_MASK)
				otg_mask_r <= pwdata;
			if (paddr == OFF_PWR_SIG)
				pwr_sig_r <= pwdata[PWR_SIG_W-1:0];
			if (paddr == OFF_IRQ_MASK)
				irq_mask_r <= pwdata[IRQ_W-1:0];
		end
	end

	// PHY control; resume flags set by hardware win over a same-cycle clear
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			phy_ctrl_r <= '0;
		else
		begin
			if (wr_en && paddr == OFF_PHY_CTRL)
				phy_ctrl_r <= pwdata & PHY_CTRL_WMASK;
			if (res_se0)
				phy_ctrl_r[PHY_RST_RES_BIT] <= 1'b1;
			if (res_k)
				phy_ctrl_r[PHY_K_RES_BIT] <= 1'b1;
		end
	end

	// Suspend controller: auto-resume only when enabled
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			susp_r       <= ST_RUN;
			resume_req_r <= 1'b0;
		end
		else
		begin
			resume_req_r <= 1'b0;
			unique case (susp_r)
				ST_RUN:
					if (suspended && phy_ctrl_r[PHY_AUTO_RES_BIT])
						susp_r <= ST_SUSPEND;
				ST_SUSPEND:
					if (!phy_ctrl_r[PHY_AUTO_RES_BIT] || !suspended)
						susp_r <= ST_RUN;
					else if (res_se0 || res_k)
					begin
						susp_r       <= ST_RUN;
						resume_req_r <= 1'b1;
					end
				default:
					susp_r <= ST_RUN;
			endcase
		end
	end

	// Receive port endpoint, marked when its special bit is set
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_ep_valid_r <= 1'b0;
			rx_ep_r       <= '0;
		end
		else
		begin
			rx_ep_valid_r <= tok_hit;
			if (tok_hit)
				rx_ep_r <= ep_special_r[tok_ep] ? ({1'b0, tok_ep} | EP_SPECIAL_OR)
				                                 : {1'b0, tok_ep};
		end
	end

	// Interrupt status: write one to clear, new events win
	assign irq_evt = {res_k, res_se0, tok_hit};
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			irq_status_r <= '0;
		else if (wr_en && paddr == OFF_IRQ_STATUS)
			irq_status_r <= (irq_status_r & ~pwdata[IRQ_W-1:0]) | irq_evt;
		else
			irq_status_r <= irq_status_r | irq_evt;
	end
	assign irq = |(irq_status_r & irq_mask_r);

	// Read mux; reserved bits zero
	always_comb
	begin
		rd_mux = '0;
		unique case (paddr)
			OFF_DEV_ADDR:   rd_mux = {25'h0, dev_addr_r};
			OFF_LAST_PID:   rd_mux = {28'h0, pid_r};
			OFF_LAST_EP:    rd_mux = {27'h0, ep_valid_r, ep_r};
			OFF_EP_SPECIAL: rd_mux = {16'h0, ep_special_r};
			OFF_OTG_MASK:   rd_mux = otg_mask_r;
			OFF_PWR_SIG:    rd_mux = {23'h0, pwr_sig_r};
			OFF_PHY_CTRL:   rd_mux = phy_ctrl_r;
			OFF_IRQ_STATUS: rd_mux = {29'h0, irq_status_r};
			OFF_IRQ_MASK:   rd_mux = {29'h0, irq_mask_r};
			default:        rd_mux = '0;
		endcase
	end

	// Read data captured in setup so it is stable through access
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			prdata_r <= '0;
		else if (rd_en)
			prdata_r <= rd_mux;
	end

	assign rx_ep_valid              = rx_ep_valid_r;
	assign rx_ep                    = rx_ep_r;
	assign resume_req               = resume_req_r;
	// Pins follow control bits directly; both pulldown enables are the inverse of the disable bit
	assign transceiver_config_pins  = phy_ctrl_r[PHY_CONF_MSB:PHY_CONF_LSB];
	assign data_port_a_pulldown_en  = !phy_ctrl_r[PHY_PD_DIS_BIT];
	assign data_port_b_pulldown_en  = !phy_ctrl_r[PHY_PD_DIS_BIT];
endmodule // utf_token_status
`default_nettype wire

// ===== utf_pkg.sv
// Register map, field positions and constants for the USB token status block
package utf_pkg;
	localparam int          ADDR_W           = 8;
	localparam logic [7:0]  OFF_DEV_ADDR     = 8'h08;
	localparam logic [7:0]  OFF_LAST_PID     = 8'h2C;
	localparam logic [7:0]  OFF_LAST_EP      = 8'h30;
	localparam logic [7:0]  OFF_EP_SPECIAL   = 8'h34;
	localparam logic [7:0]  OFF_OTG_MASK     = 8'h38;
	localparam logic [7:0]  OFF_PWR_SIG      = 8'h3C;
	localparam logic [7:0]  OFF_PHY_CTRL     = 8'h40;
	localparam logic [7:0]  OFF_IRQ_STATUS   = 8'h44;
	localparam logic [7:0]  OFF_IRQ_MASK     = 8'h48;
	localparam int          EP_VALID_BIT     = 4;
	localparam logic [4:0]  EP_SPECIAL_OR    = 5'h10;
	localparam int          PWR_SIG_W        = 9;
	localparam int          PHY_PD_DIS_BIT   = 18;
	localparam int          PHY_RST_RES_BIT  = 13;
	localparam int          PHY_K_RES_BIT    = 12;
	localparam int          PHY_FILT_LSB     = 8;
	localparam int          PHY_FILT_MSB     = 11;
	localparam int          PHY_AUTO_RES_BIT = 7;
	localparam int          PHY_CONF_LSB     = 4;
	localparam int          PHY_CONF_MSB     = 6;
	localparam logic [31:0] PHY_CTRL_WMASK   = 32'h0004_3FF0;
	localparam logic [31:0] DEV_ADDR_WMASK   = 32'h0000_007F;
	localparam logic [31:0] EP_SPECIAL_WMASK = 32'h0000_FFFF;
	localparam logic [31:0] PWR_SIG_WMASK    = 32'h0000_01FF;
	localparam int          IRQ_W            = 3;
	localparam int          IRQ_TOKEN        = 0;
	localparam int          IRQ_RST_RES      = 1;
	localparam int          IRQ_K_RES        = 2;
	localparam logic [1:0]  LS_SE0           = 2'h0;
	localparam logic [1:0]  LS_J             = 2'h1;
	localparam logic [1:0]  LS_K             = 2'h2;
	typedef enum logic [1:0] {ST_RUN, ST_SUSPEND} utf_susp_type;
endpackage

// ===== utf_line_filter.sv
// Line-state filter holding off changes for 2**log2 clocks
`timescale 1ns/100ps
`default_nettype none
module utf_line_filter
	import utf_pkg::*;
#(
	parameter int CNT_W = 16
)(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// Control
	input  wire logic [3:0] log2_delay,
	// Line state
	input  wire logic [1:0] ls_raw,
	output logic      [1:0] ls_filt
);
	logic [CNT_W-1:0] cnt_r;
	logic [1:0]       ls_filt_r;
	logic [CNT_W-1:0] limit;

	assign limit   = CNT_W'(1) << log2_delay;
	assign ls_filt = ls_filt_r;

	// Raw must differ from the filtered level for the whole window; whatever level raw has at its end passes
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_r     <= '0;
			ls_filt_r <= LS_SE0;
		end
		else if (ls_raw == ls_filt_r)
			cnt_r <= '0;
		else if (cnt_r + CNT_W'(1) >= limit)
		begin
			cnt_r     <= '0;
			ls_filt_r <= ls_raw;
		end
		else
			cnt_r <= cnt_r + CNT_W'(1);
	end
endmodule // utf_line_filter
`default_nettype wire

// ===== utf_apb_regs.sv
// APB slave decode helper: write and read strobes, mapped-address flag
`timescale 1ns/100ps
`default_nettype none
module utf_apb_regs
	import utf_pkg::*;
(
	// APB request
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	// Decode results
	output logic                   wr_en,
	output logic                   rd_en,
	output logic                   mapped
);
	always_comb
	begin
		unique case (paddr)
			OFF_DEV_ADDR, OFF_LAST_PID, OFF_LAST_EP, OFF_EP_SPECIAL, OFF_OTG_MASK,
			OFF_PWR_SIG, OFF_PHY_CTRL, OFF_IRQ_STATUS, OFF_IRQ_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign wr_en = psel && penable && pwrite && mapped;
	assign rd_en = psel && !penable && !pwrite;
endmodule // utf_apb_regs
`default_nettype wire

// ===== utf_token_status_props.sv
// Port-level assertions for the USB token status block
`timescale 1ns/100ps
`default_nettype none
module utf_token_status_props
	import utf_pkg::*;
(
	// Clock and reset
	input wire logic              mclk,
	input wire logic              rst_b,
	// APB
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pslverr,
	// Tokens
	input wire logic              tok_valid,
	input wire logic [3:0]        tok_ep,
	input wire logic              rx_ep_valid,
	input wire logic [4:0]        rx_ep,
	// Transceiver
	input wire logic [1:0]        line_state,
	input wire logic              suspended,
	input wire logic [1:0]        line_state_filt,
	input wire logic              resume_req,
	input wire logic              data_port_a_pulldown_en,
	input wire logic              data_port_b_pulldown_en
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_hole;
		paddr == 8'h00;
	endsequence
	chk_hole_err: assert property (s_acc and s_hole |-> pslverr)
		else $error("no error on unmapped access");
	chk_hole_zero: assert property (s_acc ##0 (!pwrite && paddr == 8'h00) |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_tok_cause: assert property (rx_ep_valid |-> $past(tok_valid))
		else $error("endpoint out without token");
	chk_ep_copy: assert property (rx_ep_valid |-> rx_ep[3:0] == $past(tok_ep))
		else $error("endpoint number wrong");
	chk_pd_pair: assert property (data_port_a_pulldown_en == data_port_b_pulldown_en)
		else $error("pulldown enables differ");
	chk_filt_src: assert property ($changed(line_state_filt) |-> line_state_filt == $past(line_state))
		else $error("filtered state not from raw");
	chk_res_pulse: assert property (resume_req |=> !resume_req)
		else $error("resume pulse too long");
	chk_res_cause: assert property (resume_req |-> $past(suspended) && $past(line_state_filt) != LS_J)
		else $error("resume without cause");
endmodule // utf_token_status_props
bind utf_token_status utf_token_status_props u_props (.mclk, .rst_b, .psel, .penable, .pwrite,
	.paddr, .prdata, .pslverr, .tok_valid, .tok_ep, .rx_ep_valid, .rx_ep, .line_state,
	.suspended, .line_state_filt, .resume_req, .data_port_a_pulldown_en, .data_port_b_pulldown_en);
`default_nettype wire

// ===== utf_phy_model.sv
// Transceiver model: registered line state and suspend level
`timescale 1ns/100ps
`default_nettype none
module utf_phy_model (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_b,
	// Commands from the bench
	input  wire logic [1:0] ls_cmd,
	input  wire logic       susp_cmd,
	// Line side
	output logic      [1:0] line_state,
	output logic            suspended
);
	// Line state lags the command by one clock, like a real receiver
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			line_state <= 2'h0;
			suspended  <= 1'b0;
		end
		else
		begin
			line_state <= ls_cmd;
			suspended  <= susp_cmd;
		end
endmodule // utf_phy_model
`default_nettype wire

// ===== tb_top.sv
// Register, token and resume tests for the USB token status block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import utf_pkg::*;
	logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, tok_valid;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  tok_pid, tok_ep;
	logic [6:0]  tok_addr;
	logic [1:0]  line_state, line_state_filt, ls_cmd;
	logic        rx_ep_valid, suspended, susp_cmd, resume_req, irq, pd_a, pd_b, ia;
	logic [4:0]  rx_ep;
	logic [2:0]  cfg;
	int          err_total, samples_checked;
	logic [7:0]  offs [6] = '{OFF_LAST_PID, OFF_LAST_EP, OFF_EP_SPECIAL, OFF_OTG_MASK,
		OFF_PWR_SIG, OFF_PHY_CTRL};
	logic [31:0] msk [6] = '{32'h0, 32'h0, 32'hFFFF, 32'hFFFF_FFFF, 32'h1FF, 32'h0004_3FF0};
	utf_phy_model phy (.mclk, .rst_b, .ls_cmd, .susp_cmd, .line_state, .suspended);
	utf_token_status uut (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .tok_valid, .tok_pid, .tok_addr, .tok_ep, .rx_ep_valid, .rx_ep,
		.line_state, .suspended, .line_state_filt, .resume_req, .transceiver_config_pins(cfg),
		.data_port_a_pulldown_en(pd_a), .data_port_b_pulldown_en(pd_b), .irq);
	task automatic chk(input string n, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e)
		begin
			err_total++;
			$display("BAD %0s exp %h got %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		q = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge mclk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk($sformatf("reg %h", a), q, e);
	endtask
	task automatic tok(input logic [6:0] a, input logic [3:0] p, e, input logic v,
		input logic [4:0] x);
		tok_valid <= 1;
		tok_addr <= a;
		tok_pid <= p;
		tok_ep <= e;
		@(posedge mclk);
		tok_valid <= 0;
		#1;
		chk("rx valid", rx_ep_valid, v);
		if (v)
			chk("rx ep", rx_ep, x);
		@(posedge mclk);
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	initial
	begin
		repeat (5000) @(posedge mclk);
		err_total++;
		give_verdict();
	end
	initial
	begin
		{rst_b, psel, penable, pwrite, tok_valid, susp_cmd} = '0;
		{paddr, pwdata, tok_pid, tok_ep, tok_addr, ls_cmd} = '0;
		repeat (3) @(posedge mclk);
		rst_b <= 1;
		@(posedge mclk);
		chk("pulldown", pd_a, 1);
		for (int i = 0; i < 6; i++)
			rc(offs[i], 0);
		for (int i = 0; i < 6; i++)
		begin
			apb(1, offs[i], 32'hFFFF_FFFF);
			rc(offs[i], msk[i]);
		end
		chk("config", cfg, 3'h7);
		chk("pulldown", pd_b, 0);
		apb(1, 8'h00, 32'hFFFF_FFFF);
		rc(8'h00, 0);
		apb(1, OFF_PHY_CTRL, 0);
		apb(1, OFF_EP_SPECIAL, 0);
		apb(1, OFF_DEV_ADDR, 32'h5);
		tok(3, 9, 6, 0, 0);
		rc(OFF_LAST_PID, 0);
		tok(5, 9, 6, 1, 5'h06);
		rc(OFF_LAST_PID, 9);
		rc(OFF_LAST_EP, 32'h16);
		apb(1, OFF_EP_SPECIAL, 32'h40);
		tok(5, 4'hD, 6, 1, 5'h16);
		tok(5, 1, 7, 1, 5'h07);
		rc(OFF_IRQ_STATUS, 1);
		apb(1, OFF_IRQ_MASK, 0);
		#1 ia = irq;
		@(posedge mclk);
		apb(1, OFF_IRQ_MASK, 32'h7);
		#1 chk("irq masked", ia, 0);
		chk("irq mask", irq, 1);
		@(posedge mclk);
		apb(1, OFF_IRQ_STATUS, 32'h7);
		rc(OFF_IRQ_STATUS, 0);
		chk("irq", irq, 0);
		apb(1, OFF_PHY_CTRL, 32'h280);
		ls_cmd <= LS_J;
		repeat (4) @(posedge mclk);
		#1 chk("filt hold", line_state_filt, LS_SE0);
		@(posedge mclk);
		#1 chk("filt", line_state_filt, LS_J);
		@(posedge mclk);
		for (int i = 0; i < 2; i++)
		begin
			susp_cmd <= 1;
			ls_cmd <= i ? LS_SE0 : LS_K;
			repeat (12) @(posedge mclk);
			susp_cmd <= 0;
			ls_cmd <= LS_J;
			repeat (12) @(posedge mclk);
			rc(OFF_PHY_CTRL, i ? 32'h2280 : 32'h1280);
			apb(1, OFF_PHY_CTRL, 32'h280);
			rc(OFF_PHY_CTRL, 32'h280);
		end
		rc(OFF_IRQ_STATUS, 32'h6);
		apb(1, OFF_PHY_CTRL, 32'h200);
		susp_cmd <= 1;
		ls_cmd <= LS_K;
		repeat (12) @(posedge mclk);
		chk("poll filt", line_state_filt, LS_K);
		rc(OFF_PHY_CTRL, 32'h200);
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
